// [include/prps_map.svh]
// constants of the pci reset pin sequencer: timing counts and idle values
`ifndef PRPS_MAP_SVH
`define PRPS_MAP_SVH

// ========================================================
// clock and timing
// ========================================================
`define PRPS_CLK_PERIOD_NS  40
// extra clocks spent waiting before the parked bus is driven low
`define PRPS_PARK_DLY_CYC   1
`define PRPS_PARK_CNT_W     2
// shortest legal bus reset pulse, in ns and in clocks (rounded up)
`define PRPS_RST_MIN_NS     1000
`define PRPS_RST_MIN_CYC    \
  ((`PRPS_RST_MIN_NS + `PRPS_CLK_PERIOD_NS - 1) / `PRPS_CLK_PERIOD_NS)
`define PRPS_RST_CNT_W      6

// ========================================================
// line counts and idle values
// ========================================================
`define PRPS_NUM_STS        5
`define PRPS_NUM_GNT        3
`define PRPS_STS_IDLE       5'h1F
`define PRPS_GNT_IDLE       3'h7
`define PRPS_HOLD_RST       5'h1F

`endif

// [include/prps_pkg.sv]
// types shared by the pci reset pin sequencer
`include "prps_map.svh"

package prps_pkg;

  // ========================================================
  // sequencer states, gray coded along reset, wait, park, run
  // ========================================================
  typedef enum logic [1:0] {
    PRPS_ST_RESET = 2'h0,
    PRPS_ST_WAIT  = 2'h1,
    PRPS_ST_PARK  = 2'h3,
    PRPS_ST_RUN   = 2'h2
  } prps_state_e;

  // ========================================================
  // pin groups
  // ========================================================
  // sustained tri-state controls, one bit per line
  typedef struct packed {
    logic frame;
    logic irdy;
    logic trdy;
    logic stop;
    logic devsel;
  } prps_sts_s;

  // address/data, command/byte enables and parity
  typedef struct packed {
    logic [31:0] ad;
    logic [3:0]  cbe_n;
    logic        par;
  } prps_bus_s;

  // arbiter grants, active high from the arbiter core
  typedef struct packed {
    logic host;
    logic grant0;
    logic grant1;
  } prps_gnt_s;

endpackage

// [core/prps_sequencer.sv]
// pci side pin sequencer around bus reset: drive, park and release of pins
`timescale 1ns/100ps
`include "prps_map.svh"

module prps_sequencer #(
  parameter int CLK_PERIOD_NS = `PRPS_CLK_PERIOD_NS,
  parameter int PARK_DLY_CYC  = `PRPS_PARK_DLY_CYC
) (
  input  wire                   ref_clk,
  input  wire                   srst,
  input  wire                   bus_reset_n,
  input  wire                   host_request_strap_n,
  input  wire                   core_bus_drive,
  input  wire prps_pkg::prps_bus_s core_bus,
  input  wire                   bus_given_away,
  input  wire prps_pkg::prps_sts_s sts_own,
  input  wire prps_pkg::prps_sts_s sts_assert,
  input  wire                   core_mem_req,
  input  wire                   core_flush_req,
  input  wire prps_pkg::prps_gnt_s arb_grant,
  output prps_pkg::prps_bus_s   bus_o,
  output logic                  bus_oe,
  output prps_pkg::prps_sts_s   sts_n_o,
  output prps_pkg::prps_sts_s   sts_oe,
  output logic                  memory_request_n,
  output logic                  memory_request_oe,
  output logic                  buffer_flush_request_n,
  output logic                  buffer_flush_request_oe,
  output logic                  host_grant_n,
  output logic                  grant0_or_bridge_request_n,
  output logic                  grant1_or_resume_n,
  output logic                  grant_oe,
  output logic                  arbiter_enable,
  output logic                  in_reset,
  output logic                  reset_short
);

  // ========================================================
  // helpers
  // ========================================================
  // pin level for an asserted/negated active-low line
  function automatic logic pin_lvl_n(input logic asserted);
    pin_lvl_n = ~asserted;
  endfunction

  // saturating increment of the reset length counter
  function automatic logic [`PRPS_RST_CNT_W-1:0] sat_inc(
    input logic [`PRPS_RST_CNT_W-1:0] v
  );
    sat_inc = (&v) ? v : v + `PRPS_RST_CNT_W'(1);
  endfunction

  // ========================================================
  // declarations
  // ========================================================
  logic                         bus_rst_n_s1_q;
  logic                         bus_rst_n_s2_q;
  logic                         strap_n_s1_q;
  logic                         strap_n_s2_q;
  logic                         rst_all;
  logic                         release_now;
  prps_pkg::prps_state_e        state_q;
  logic [`PRPS_PARK_CNT_W-1:0]  park_cnt_q;
  logic [`PRPS_RST_CNT_W-1:0]   rst_cnt_q;
  logic [`PRPS_NUM_STS-1:0]     sts_lvl_q;
  logic [`PRPS_NUM_STS-1:0]     sts_oe_q;
  logic [`PRPS_NUM_STS-1:0]     sts_hold_q;
  logic [`PRPS_NUM_STS-1:0]     own_v;
  logic [`PRPS_NUM_STS-1:0]     asrt_v;

  localparam logic [`PRPS_PARK_CNT_W-1:0] PARK_LOAD =
    `PRPS_PARK_CNT_W'(PARK_DLY_CYC - 1);
  localparam logic [`PRPS_RST_CNT_W-1:0] RST_MIN =
    `PRPS_RST_CNT_W'((`PRPS_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ========================================================
  // pin synchronisers
  // ========================================================
  // reset and strap pins are asynchronous to the bus clock
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bus_rst_n_s1_q <= 1'b0;
      bus_rst_n_s2_q <= 1'b0;
    end else begin
      bus_rst_n_s1_q <= bus_reset_n;
      bus_rst_n_s2_q <= bus_rst_n_s1_q;
    end
  end

  // strap goes through the same depth so both line up at release
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      strap_n_s1_q <= 1'b0;
      strap_n_s2_q <= 1'b0;
    end else begin
      strap_n_s1_q <= host_request_strap_n;
      strap_n_s2_q <= strap_n_s1_q;
    end
  end

  // chip reset or synchronised bus reset, both restore defaults
  assign rst_all     = srst | ~bus_rst_n_s2_q;
  // first clock after reset leaves: strap capture point
  assign release_now = ~rst_all && (state_q == prps_pkg::PRPS_ST_RESET);

  // ========================================================
  // release sequencing
  // ========================================================
  // reset -> (wait -> park) -> run; park only with arbiter on
  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      state_q <= prps_pkg::PRPS_ST_RESET;
    end else begin
      unique case (state_q)
        prps_pkg::PRPS_ST_RESET: begin
          if (strap_n_s2_q) begin
            state_q <= prps_pkg::PRPS_ST_WAIT;
          end else begin
            state_q <= prps_pkg::PRPS_ST_RUN;
          end
        end
        prps_pkg::PRPS_ST_WAIT: begin
          if (park_cnt_q == '0) begin
            state_q <= prps_pkg::PRPS_ST_PARK;
          end
        end
        prps_pkg::PRPS_ST_PARK: begin
          if (bus_given_away) begin
            state_q <= prps_pkg::PRPS_ST_RUN;
          end
        end
        prps_pkg::PRPS_ST_RUN: begin
          state_q <= prps_pkg::PRPS_ST_RUN;
        end
      endcase
    end
  end

  // park delay counter, loaded as wait is entered
  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      park_cnt_q <= '0;
    end else if (release_now) begin
      park_cnt_q <= PARK_LOAD;
    end else if (park_cnt_q != '0) begin
      park_cnt_q <= park_cnt_q - `PRPS_PARK_CNT_W'(1);
    end
  end

  // strap sampled once, at the release clock
  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      arbiter_enable <= 1'b0;
    end else if (release_now) begin
      arbiter_enable <= strap_n_s2_q;
    end
  end

  // ========================================================
  // reset length watch
  // ========================================================
  // flags a bus reset pulse shorter than the legal minimum;
  // the device cannot stretch it, only report it
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rst_cnt_q   <= '1; // saturated: a chip reset alone never reads as short
      reset_short <= 1'b0;
    end else if (!bus_rst_n_s2_q) begin
      rst_cnt_q   <= sat_inc(rst_cnt_q);
      reset_short <= 1'b0;
    end else begin
      reset_short <= (rst_cnt_q != '0) && (rst_cnt_q < RST_MIN);
      rst_cnt_q   <= '0;
    end
  end

  // reset status, one clock behind the internal reset
  always_ff @(posedge ref_clk) begin
    in_reset <= rst_all;
  end

  // ========================================================
  // address/data, command and parity
  // ========================================================
  // low in reset, float at release, low again while parked
  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      bus_oe <= 1'b1;
      bus_o  <= '0;
    end else begin
      unique case (state_q)
        prps_pkg::PRPS_ST_RESET: begin
          bus_oe <= 1'b0;
          bus_o  <= '0;
        end
        prps_pkg::PRPS_ST_WAIT: begin
          bus_oe <= (park_cnt_q == '0);
          bus_o  <= '0;
        end
        prps_pkg::PRPS_ST_PARK: begin
          // handing over ends the park on the same clock
          bus_oe <= ~bus_given_away;
          bus_o  <= '0;
        end
        prps_pkg::PRPS_ST_RUN: begin
          bus_oe <= core_bus_drive;
          bus_o  <= core_bus;
        end
      endcase
    end
  end

  // ========================================================
  // sustained tri-state controls
  // ========================================================
  assign own_v  = sts_own;
  assign asrt_v = sts_assert;

  // per line: drive while owned, one high clock on hand-back,
  // then float and refuse a new drive for one clock
  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      sts_oe_q   <= '0;
      sts_lvl_q  <= `PRPS_STS_IDLE;
      sts_hold_q <= `PRPS_HOLD_RST;
    end else begin
      for (int i = 0; i < `PRPS_NUM_STS; i++) begin
        if (sts_oe_q[i]) begin
          if (own_v[i]) begin
            sts_lvl_q[i] <= pin_lvl_n(asrt_v[i]);
          end else if (!sts_lvl_q[i]) begin
            sts_lvl_q[i] <= 1'b1;
          end else begin
            sts_oe_q[i]   <= 1'b0;
            sts_hold_q[i] <= 1'b1;
          end
        end else if (own_v[i] && !sts_hold_q[i]) begin
          sts_oe_q[i]  <= 1'b1;
          sts_lvl_q[i] <= pin_lvl_n(asrt_v[i]);
        end else begin
          sts_hold_q[i] <= 1'b0;
        end
      end
    end
  end

  // ports taken straight from the line flops
  assign sts_n_o = sts_lvl_q;
  assign sts_oe  = sts_oe_q;

  // ========================================================
  // requests and grants
  // ========================================================
  // float in reset; driven from the first clock after release.
  // a true asynchronous drive would need a gate after the flop,
  // so the inactive level arrives on the release clock instead
  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      memory_request_oe       <= 1'b0;
      buffer_flush_request_oe <= 1'b0;
      memory_request_n        <= 1'b1;
      buffer_flush_request_n  <= 1'b1;
    end else begin
      memory_request_oe       <= 1'b1;
      buffer_flush_request_oe <= 1'b1;
      memory_request_n        <= pin_lvl_n(core_mem_req & ~release_now);
      buffer_flush_request_n  <= pin_lvl_n(core_flush_req & ~release_now);
    end
  end

  // grants follow the arbiter core once out of reset
  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      grant_oe                   <= 1'b0;
      {host_grant_n, grant0_or_bridge_request_n, grant1_or_resume_n}
        <= `PRPS_GNT_IDLE;
    end else begin
      grant_oe                   <= 1'b1;
      host_grant_n               <= pin_lvl_n(arb_grant.host);
      grant0_or_bridge_request_n <= pin_lvl_n(arb_grant.grant0);
      grant1_or_resume_n         <= pin_lvl_n(arb_grant.grant1);
    end
  end

  // clock rate is set by CLK_PERIOD_NS: 40 for 25 MHz, 30 for 33 MHz
  // only the reset length watch depends on it

endmodule // prps_sequencer

// [testbench/prps_sequencer_asserts.sv]
// port assertions for the pci reset pin sequencer
`timescale 1ns/100ps
module prps_seq_chk (
  input wire                      ref_clk,
  input wire                      srst,
  input wire                      bus_reset_n,
  input wire                      host_request_strap_n,
  input wire                      core_bus_drive,
  input wire                      bus_given_away,
  input wire prps_pkg::prps_sts_s sts_own,
  input wire prps_pkg::prps_sts_s sts_assert,
  input wire                      core_mem_req,
  input wire                      core_flush_req,
  input wire prps_pkg::prps_gnt_s arb_grant,
  input wire prps_pkg::prps_bus_s bus_o,
  input wire logic                bus_oe,
  input wire prps_pkg::prps_sts_s sts_n_o,
  input wire prps_pkg::prps_sts_s sts_oe,
  input wire logic                memory_request_n,
  input wire logic                memory_request_oe,
  input wire logic                buffer_flush_request_n,
  input wire logic                host_grant_n,
  input wire logic                grant0_or_bridge_request_n,
  input wire logic                grant1_or_resume_n,
  input wire logic                grant_oe,
  input wire logic                arbiter_enable,
  input wire logic                in_reset
);
  // ======================================================
  // one domain; chip reset masks every check
  // ======================================================
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  // reset pin released and held, strap steady
  sequence s_up_hi;
    $rose(bus_reset_n) ##1 (bus_reset_n && host_request_strap_n && !bus_given_away) [*5];
  endsequence
  sequence s_up_lo;
    $rose(bus_reset_n) ##1 (bus_reset_n && !host_request_strap_n && !core_bus_drive) [*5];
  endsequence

  property p_rst_pins;
    in_reset |-> bus_oe && bus_o == 37'h0 && sts_oe == 5'h0 && !grant_oe
      && !memory_request_oe && !arbiter_enable;
  endproperty
  a_rst_pins: assert property (p_rst_pins) else $error("pins not forced in reset");
  property p_release;
    $fell(in_reset) |-> !bus_oe && sts_oe == 5'h0 && memory_request_oe && memory_request_n
      && buffer_flush_request_n && host_grant_n == !$past(arb_grant.host);
  endproperty
  a_release: assert property (p_release) else $error("bad pins at release");
  property p_park;
    s_up_hi |-> bus_oe && bus_o == 37'h0 && arbiter_enable;
  endproperty
  a_park: assert property (p_park) else $error("bus not parked low");
  property p_float;
    s_up_lo |-> !bus_oe && !arbiter_enable;
  endproperty
  a_float: assert property (p_float) else $error("bus driven with arbiter off");
  property p_sts_gap;
    grant_oe |-> ($past(sts_oe) & ~sts_oe & ~$past(sts_n_o)) == 5'h0;
  endproperty
  a_sts_gap: assert property (p_sts_gap) else $error("line floated from low");
  property p_sts_hold;
    grant_oe && $past(grant_oe) |-> ($past(sts_oe, 2) & ~$past(sts_oe) & sts_oe) == 5'h0;
  endproperty
  a_sts_hold: assert property (p_sts_hold) else $error("line driven right after float");
  property p_sts_lvl;
    grant_oe && $past(grant_oe) |-> (sts_oe & ~$past(sts_oe) & ~$past(sts_own)) == 5'h0
      && (sts_oe & $past(sts_own) & (sts_n_o ^ ~$past(sts_assert))) == 5'h0;
  endproperty
  a_sts_lvl: assert property (p_sts_lvl) else $error("line level or claim wrong");
  property p_follow;
    grant_oe && $past(grant_oe) |-> {host_grant_n, grant0_or_bridge_request_n,
      grant1_or_resume_n} == ~$past(arb_grant) && memory_request_n == !$past(core_mem_req)
      && buffer_flush_request_n == !$past(core_flush_req);
  endproperty
  a_follow: assert property (p_follow) else $error("grant or request wrong");
endmodule // prps_seq_chk

bind prps_sequencer prps_seq_chk u_chk (.ref_clk, .srst, .bus_reset_n, .host_request_strap_n,
  .core_bus_drive, .bus_given_away, .sts_own, .sts_assert, .core_mem_req, .core_flush_req,
  .arb_grant, .bus_o, .bus_oe, .sts_n_o, .sts_oe, .memory_request_n, .memory_request_oe,
  .buffer_flush_request_n, .host_grant_n, .grant0_or_bridge_request_n, .grant1_or_resume_n,
  .grant_oe, .arbiter_enable, .in_reset);

// [testbench/prps_pci_agent.sv]
// far side model: reset source, arbiter strap and the next bus master
`timescale 1ns/100ps
module prps_pci_agent (
  input  wire                      ref_clk,
  input  wire                      bus_oe,
  input  wire prps_pkg::prps_bus_s bus_o,
  input  wire                      arbiter_enable,
  output logic                     bus_reset_n,
  output logic                     host_request_strap_n,
  output logic                     bus_given_away
);
  int park_cnt = 0;
  // power-up: bus reset held from time zero
  initial begin
    bus_reset_n = 1'b0;
    host_request_strap_n = 1'b1;
    bus_given_away = 1'b0;
  end
  // edges land off the clock grid on purpose; one clean rising edge
  task automatic pulse(input int cyc, input logic strap);
    #3 bus_reset_n = 1'b0;
    host_request_strap_n = strap;
    repeat (cyc) @(posedge ref_clk);
    #13 bus_reset_n = 1'b1;
  endtask
  // take the parked bus after three quiet clocks
  always @(posedge ref_clk) begin
    park_cnt <= (arbiter_enable && bus_oe && bus_o == 37'h0) ? park_cnt + 1 : 0;
    bus_given_away <= (park_cnt >= 3);
  end
endmodule // prps_pci_agent

// [testbench/tb_pci_reset_pin_sequencer.sv]
// self-checking bench for the pci reset pin sequencer
`timescale 1ns/100ps
module tb_pci_reset_pin_sequencer;
  // ======================================================
  // pins and counters
  // ======================================================
  logic                ref_clk = 1'b0;
  logic                srst = 1'b1;
  logic                core_bus_drive = 1'b0;
  logic                core_mem_req = 1'b0;
  logic                core_flush_req = 1'b0;
  prps_pkg::prps_bus_s core_bus = 37'h0;
  prps_pkg::prps_sts_s sts_own = 5'h0;
  prps_pkg::prps_sts_s sts_assert = 5'h0;
  prps_pkg::prps_gnt_s arb_grant = 3'h0;
  prps_pkg::prps_bus_s bus_o;
  prps_pkg::prps_sts_s sts_n_o, sts_oe, a;
  logic bus_given_away, bus_reset_n, host_request_strap_n, bus_oe, memory_request_n;
  logic memory_request_oe, buffer_flush_request_n, buffer_flush_request_oe, host_grant_n;
  logic grant0_or_bridge_request_n, grant1_or_resume_n, grant_oe, arbiter_enable;
  logic in_reset, reset_short;
  int   error_cnt = 0;
  int   n_checks = 0;
  int   i;

  // 25 MHz clock
  always #20 ref_clk = ~ref_clk;

  prps_sequencer dut (.ref_clk, .srst, .bus_reset_n, .host_request_strap_n, .core_bus_drive,
    .core_bus, .bus_given_away, .sts_own, .sts_assert, .core_mem_req, .core_flush_req,
    .arb_grant, .bus_o, .bus_oe, .sts_n_o, .sts_oe, .memory_request_n, .memory_request_oe,
    .buffer_flush_request_n, .buffer_flush_request_oe, .host_grant_n,
    .grant0_or_bridge_request_n, .grant1_or_resume_n, .grant_oe, .arbiter_enable,
    .in_reset, .reset_short);

  prps_pci_agent agent (.ref_clk, .bus_oe, .bus_o, .arbiter_enable, .bus_reset_n,
    .host_request_strap_n, .bus_given_away);

  // ======================================================
  // helpers
  // ======================================================
  task automatic chk(input string nm, input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // grant pins are active low
  function automatic logic [2:0] pins(input prps_pkg::prps_gnt_s g);
    return ~g;
  endfunction
  task automatic chk_rst();
    chk("bus", {bus_oe, bus_o}, 38'h2000000000);
    chk("sts_oe", sts_oe, 5'h00);
    chk("oes", {memory_request_oe, buffer_flush_request_oe, grant_oe}, 3'h0);
    chk("arb_en", arbiter_enable, 1'b0);
    chk("in_reset", in_reset, 1'b1);
  endtask
  // sh below zero skips the short-reset flag
  task automatic chk_release(input int n, input logic strap, input int sh);
    cyc(n);
    chk("rel_oe", {bus_oe, sts_oe}, 6'h00);
    chk("arb_en", arbiter_enable, strap);
    chk("req_n", {memory_request_oe, memory_request_n, buffer_flush_request_n}, 3'h7);
    chk("gnt_oe", grant_oe, 1'b1);
    chk("in_reset", in_reset, 1'b0);
    if (sh >= 0) begin
      chk("short", reset_short, sh[0]);
    end
  endtask
  // random core traffic; expectations one clock later
  task automatic traffic(input int n);
    prps_pkg::prps_bus_s b;
    prps_pkg::prps_gnt_s g;
    logic d, m, f;
    repeat (n) begin
      d = 1'($urandom);
      b = 37'({$urandom, $urandom});
      g = 3'($urandom);
      m = 1'($urandom);
      f = 1'($urandom);
      core_bus_drive = d;
      core_bus = b;
      arb_grant = g;
      core_mem_req = m;
      core_flush_req = f;
      cyc(1);
      chk("bus", {bus_oe, bus_o & {37{d}}}, {d, b & {37{d}}});
      chk("gnts", {host_grant_n, grant0_or_bridge_request_n, grant1_or_resume_n}, pins(g));
      chk("reqs", {memory_request_n, buffer_flush_request_n}, {~m, ~f});
    end
    core_bus_drive = 1'b0;
  endtask

  // ======================================================
  // main sequence
  // ======================================================
  initial begin
    void'($urandom(32'hD4D0));
    cyc(2);
    srst = 1'b0;
    cyc(1);
    chk_rst();
    // strap high: park, hand-over, then traffic
    agent.pulse(30, 1'b1);
    chk_release(4, 1'b1, 0);
    cyc(1);
    for (i = 0; i < 20 && bus_oe; i++) begin
      chk("park", {bus_oe, bus_o}, 38'h2000000000);
      cyc(1);
    end
    chk("park_end", bus_oe, 1'b0);
    if (bus_oe) begin
      tally_and_finish();
    end
    traffic(24);
    // sustained lines: claim, drive high, float, refused re-claim
    a = 5'($urandom);
    sts_own = 5'h1F;
    sts_assert = a;
    cyc(1);
    chk("sts", {sts_oe, sts_n_o}, {5'h1F, ~a});
    sts_assert = 5'h1F;
    cyc(1);
    sts_own = 5'h00;
    cyc(1);
    chk("sts_hi", {sts_oe, sts_n_o}, 10'h3FF);
    cyc(1);
    chk("sts_off", sts_oe, 5'h00);
    sts_own = 5'h1F;
    cyc(1);
    chk("sts_gap", sts_oe, 5'h00);
    cyc(1);
    chk("sts_on", {sts_oe, sts_n_o}, 10'h3E0);
    sts_own = 5'h00;
    cyc(3);
    // short bus reset, strap low, checked while held
    fork
      agent.pulse(10, 1'b0);
      begin
        cyc(6);
        chk_rst();
      end
    join
    chk_release(4, 1'b0, 1);
    cyc(2);
    chk("float", bus_oe, 1'b0);
    traffic(24);
    // chip reset in mid-run
    srst = 1'b1;
    cyc(2);
    chk_rst();
    srst = 1'b0;
    chk_release(3, 1'b0, 0);
    traffic(8);
    tally_and_finish();
  end
endmodule // tb_pci_reset_pin_sequencer
